// File: icc_fifo.sv
// shift-forward capture buffer, head is always the oldest word
// drops a push when full and not popped in the same cycle; push with a pop is accepted
`timescale 1ns/1ps
module icc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    // control
    input  wire logic             i_flush,
    input  wire logic             i_push,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_pop,
    // state
    output logic      [WIDTH-1:0] o_head,
    output logic      [CW-1:0]    o_count
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0]               cnt;
    } icc_fifo_st_t;

    icc_fifo_st_t q;
    icc_fifo_st_t d;

    always_comb begin
        d = q;
        if (i_pop && q.cnt != '0) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                d.mem[i] = q.mem[i+1];
            end
            d.cnt = q.cnt - CW'(1);
        end
        if (i_push && d.cnt != CW'(DEPTH)) begin
            d.mem[d.cnt] = i_data;
            d.cnt        = d.cnt + CW'(1);
        end
        if (i_flush) begin
            d.cnt = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_head  = q.mem[0];
    assign o_count = q.cnt;
endmodule

// File: icc_input_capture.sv
// eight input capture channels, each with prescaler, four-word buffer and flags
// assumes timer counts, control fields and read strobes are synchronous to i_clk
`timescale 1ns/1ps
// How it works
// - eight channels, each with own control, timer pick, buffer and flags
// - mode field picks falling, rising, 4th rising, 16th rising or both edges
// - mode picks prescale; edge counter cleared when channel turned off
// - any reset clears the prescaler edge counter
// - each channel buffers four 16-bit captured counts
// - not-empty flag set on first capture, held until all read
// - a read returns the oldest word; the rest move forward
// - fifth event into full buffer before a read sets overflow
// - the overflowing capture is dropped, never stored
// - after overflow no captures are stored until buffer fully read
// - bit 7 picks which of two 16-bit timers is captured
// - bit 7 at reset value selects the second timer
// - both-edge mode captures every edge while the buffer has room, flags interrupt on every edge
// - both-edge mode ignores events-per-interrupt, one interrupt per edge
// - both-edge mode never raises overflow
// - bits 6:5 set events counted before the interrupt flag
// - mode 111 with interrupt enabled wakes on rising edge, timer or not
module icc_input_capture
    import icc_pkg::*;
#(
    parameter int NCH   = icc_pkg::ICC_CHANNELS,
    parameter int DEPTH = icc_pkg::ICC_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                                i_clk,
    input  wire logic                                i_srst,
    // capture pins
    input  wire logic            [NCH-1:0]           i_pin,
    // timer sources
    input  wire logic            [icc_pkg::ICC_TMR_W-1:0] i_timer2,
    input  wire logic            [icc_pkg::ICC_TMR_W-1:0] i_timer3,
    // power state
    input  wire logic                                i_cpu_idle,
    input  wire logic                                i_cpu_sleep,
    // per-channel control and strobes
    input  icc_pkg::icc_ctrl_t   [NCH-1:0]           i_ctrl,
    input  wire logic            [NCH-1:0]           i_int_enable,
    input  wire logic            [NCH-1:0]           i_rd,
    input  wire logic            [NCH-1:0]           i_ovf_clr,
    // per-channel results
    output logic [NCH-1:0][icc_pkg::ICC_TMR_W-1:0]   o_rd_data,
    output icc_pkg::icc_ctrl_t   [NCH-1:0]           o_status,
    output logic                 [NCH-1:0]           o_int_pulse,
    output logic                 [NCH-1:0]           o_wake
);
    import icc_pkg::*;

    localparam int CW = $clog2(DEPTH + 1);

    icc_chan_t [NCH-1:0]                 q;
    icc_chan_t [NCH-1:0]                 d;

    logic      [NCH-1:0]                 rise_w;
    logic      [NCH-1:0]                 fall_w;
    logic      [NCH-1:0]                 push_w;
    logic      [NCH-1:0]                 pop_w;
    logic      [NCH-1:0]                 flush_w;
    logic      [NCH-1:0][ICC_TMR_W-1:0]  tsel_w;
    logic      [NCH-1:0][ICC_TMR_W-1:0]  head_w;
    logic      [NCH-1:0][CW-1:0]         cnt_w;

    // one synchroniser and one buffer per channel
    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        icc_sync u_sync (
            .i_clk  (i_clk),
            .i_srst (i_srst),
            .i_pin  (i_pin[ch]),
            .o_rise (rise_w[ch]),
            .o_fall (fall_w[ch])
        );

        // reset value of the select bit means the second timer
        assign tsel_w[ch] = (i_ctrl[ch].timebase_select == ICC_TMR_SEL_T3) ? i_timer3
                                                                          : i_timer2;

        icc_fifo #(
            .WIDTH (ICC_TMR_W),
            .DEPTH (DEPTH),
            .CW    (CW)
        ) u_fifo (
            .i_clk   (i_clk),
            .i_srst  (i_srst),
            .i_flush (flush_w[ch]),
            .i_push  (push_w[ch]),
            .i_data  (tsel_w[ch]),
            .i_pop   (pop_w[ch]),
            .o_head  (head_w[ch]),
            .o_count (cnt_w[ch])
        );
    end

    always_comb begin
        logic [2:0]    mode;
        logic          halted;
        logic          rise;
        logic          fall;
        logic          evt;
        logic          cap_evt;
        logic          full;
        logic          ovf_set;
        logic [CW-1:0] cnt_next;
        mode     = ICC_MODE_OFF;
        halted   = 1'b0;
        rise     = 1'b0;
        fall     = 1'b0;
        evt      = 1'b0;
        cap_evt  = 1'b0;
        full     = 1'b0;
        ovf_set  = 1'b0;
        cnt_next = '0;
        d        = q;
        push_w   = '0;
        pop_w    = '0;
        flush_w  = '0;
        for (int ch = 0; ch < NCH; ch++) begin
            mode = i_ctrl[ch].capture_mode_select;
            // idle-stop freezes the channel; in sleep only the wake mode runs
            halted = (i_cpu_idle && i_ctrl[ch].idle_stop_bit)
                   || (i_cpu_sleep && mode != ICC_MODE_WAKE_RISE);
            rise   = rise_w[ch] && !halted;
            fall   = fall_w[ch] && !halted;
            evt    = 1'b0;
            d[ch].int_pulse  = 1'b0;
            d[ch].wake_pulse = 1'b0;

            case (mode)
                ICC_MODE_EVERY_EDGE: begin
                    evt = rise || fall;
                end
                ICC_MODE_FALL: begin
                    evt = fall;
                end
                ICC_MODE_RISE: begin
                    evt = rise;
                end
                ICC_MODE_RISE4: begin
                    if (rise) begin
                        if (q[ch].presc >= ICC_PRESC4_LAST) begin
                            evt          = 1'b1;
                            d[ch].presc  = ICC_PRESC_RST;
                        end else begin
                            d[ch].presc  = q[ch].presc + ICC_PRESC_STEP;
                        end
                    end
                end
                ICC_MODE_RISE16: begin
                    if (rise) begin
                        if (q[ch].presc == ICC_PRESC16_LAST) begin
                            evt          = 1'b1;
                            d[ch].presc  = ICC_PRESC_RST;
                        end else begin
                            d[ch].presc  = q[ch].presc + ICC_PRESC_STEP;
                        end
                    end
                end
                ICC_MODE_WAKE_RISE: begin
                    evt = rise;
                end
                default: begin
                    evt = 1'b0;
                end
            endcase

            // turning the channel off clears prescaler, buffer and flags
            if (mode == ICC_MODE_OFF) begin
                d[ch].presc = ICC_PRESC_RST;
                d[ch].icnt  = ICC_ICNT_RST;
                flush_w[ch] = 1'b1;
            end

            // wake mode is interrupt only; it stores nothing
            cap_evt    = evt && mode != ICC_MODE_WAKE_RISE;
            pop_w[ch]  = i_rd[ch] && cnt_w[ch] != '0;
            full       = cnt_w[ch] == CW'(DEPTH);
            // a read in the same cycle makes room for the new word
            push_w[ch] = cap_evt && !q[ch].blocked && (!full || pop_w[ch]);
            // both-edge mode drops quietly instead of flagging
            ovf_set    = cap_evt && !q[ch].blocked && full && !pop_w[ch]
                       && mode != ICC_MODE_EVERY_EDGE;

            cnt_next = cnt_w[ch] - CW'(pop_w[ch]) + CW'(push_w[ch]);
            if (flush_w[ch]) begin
                cnt_next = '0;
            end

            // stall holds until every buffered word has been read
            d[ch].blocked = (q[ch].blocked && cnt_next != '0) || ovf_set;

            // empty reads return a stale head, contents undefined
            if (i_rd[ch]) begin
                d[ch].rd_data = head_w[ch];
            end

            if (evt) begin
                if (mode == ICC_MODE_EVERY_EDGE || mode == ICC_MODE_WAKE_RISE) begin
                    d[ch].int_pulse = 1'b1;
                    d[ch].icnt      = ICC_ICNT_RST;
                end else if (q[ch].icnt == i_ctrl[ch].events_per_interrupt) begin
                    d[ch].int_pulse = 1'b1;
                    d[ch].icnt      = ICC_ICNT_RST;
                end else begin
                    d[ch].icnt      = q[ch].icnt + ICC_ICNT_STEP;
                end
            end

            // wake ignores the timer entirely
            d[ch].wake_pulse = evt && mode == ICC_MODE_WAKE_RISE && i_int_enable[ch];

            d[ch].status = i_ctrl[ch];
            d[ch].status.buffer_not_empty_flag = cnt_next != '0;
            // set beats clear in the same cycle
            d[ch].status.capture_overflow_flag = ovf_set
                || (q[ch].status.capture_overflow_flag && !i_ovf_clr[ch]
                    && mode != ICC_MODE_OFF);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int ch = 0; ch < NCH; ch++) begin
                q[ch].presc      <= ICC_PRESC_RST;
                q[ch].icnt       <= ICC_ICNT_RST;
                q[ch].blocked    <= 1'b0;
                q[ch].rd_data    <= '0;
                q[ch].int_pulse  <= 1'b0;
                q[ch].wake_pulse <= 1'b0;
                q[ch].status     <= ICC_CTRL_RST;
            end
        end else begin
            q <= d;
        end
    end

    always_comb begin
        for (int ch = 0; ch < NCH; ch++) begin
            o_rd_data[ch]   = q[ch].rd_data;
            o_status[ch]    = q[ch].status;
            o_int_pulse[ch] = q[ch].int_pulse;
            o_wake[ch]      = q[ch].wake_pulse;
        end
    end
endmodule

// File: icc_input_capture_chk.sv
// assertions on channel 0 of the capture top, reset check on all channels
// assumes a bind to icc_input_capture, one clock domain
`timescale 1ns/1ps
module icc_input_capture_chk
    import icc_pkg::*;
#(
    parameter int NCH   = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic                                  i_clk,
    input wire logic                                  i_srst,
    // inputs of the top
    input wire logic [NCH-1:0]                        i_pin,
    input wire logic [icc_pkg::ICC_TMR_W-1:0]         i_timer2,
    input wire logic [icc_pkg::ICC_TMR_W-1:0]         i_timer3,
    input wire logic                                  i_cpu_idle,
    input wire logic                                  i_cpu_sleep,
    input icc_pkg::icc_ctrl_t [NCH-1:0]               i_ctrl,
    input wire logic [NCH-1:0]                        i_int_enable,
    input wire logic [NCH-1:0]                        i_rd,
    input wire logic [NCH-1:0]                        i_ovf_clr,
    // outputs of the top
    input wire logic [NCH-1:0][icc_pkg::ICC_TMR_W-1:0] o_rd_data,
    input icc_pkg::icc_ctrl_t [NCH-1:0]               o_status,
    input wire logic [NCH-1:0]                        o_int_pulse,
    input wire logic [NCH-1:0]                        o_wake
);
    logic [2:0] mode0;
    logic       quiet;
    assign mode0 = i_ctrl[0].capture_mode_select;
    assign quiet = !i_cpu_idle && !i_cpu_sleep && !i_rd[0];

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    property p_rst_clear;
        $fell(i_srst) |-> o_status == '0 && o_int_pulse == '0 && o_wake == '0;
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("outputs not clear after reset");

    // every-edge mode must never flag overflow, however full
    property p_ovf_not_ee;
        $rose(o_status[0].capture_overflow_flag) |-> $past(mode0) != ICC_MODE_EVERY_EDGE;
    endproperty
    a_ovf_not_ee: assert property (p_ovf_not_ee)
        else $error("overflow raised in every-edge mode");

    property p_int_both;
        $changed(i_pin[0]) && mode0 == ICC_MODE_EVERY_EDGE
            ##1 (mode0 == ICC_MODE_EVERY_EDGE && quiet)[*2] |=> o_int_pulse[0];
    endproperty
    a_int_both: assert property (p_int_both)
        else $error("no interrupt pulse for an edge");

    property p_cap_bne;
        $rose(i_pin[0]) && mode0 == ICC_MODE_RISE
            ##1 (mode0 == ICC_MODE_RISE && quiet)[*2] |=> o_status[0].buffer_not_empty_flag;
    endproperty
    a_cap_bne: assert property (p_cap_bne)
        else $error("not-empty flag missing after capture");

    property p_bne_fall;
        $fell(o_status[0].buffer_not_empty_flag)
            |-> $past(i_rd[0]) || $past(mode0) == ICC_MODE_OFF || $past(i_srst);
    endproperty
    a_bne_fall: assert property (p_bne_fall)
        else $error("not-empty flag dropped without a read");

    property p_rd_hold;
        !i_rd[0] |=> $stable(o_rd_data[0]);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without a read");

    property p_off_flush;
        mode0 == ICC_MODE_OFF |=> !o_status[0].buffer_not_empty_flag
            && !o_status[0].capture_overflow_flag;
    endproperty
    a_off_flush: assert property (p_off_flush)
        else $error("channel off but flags still set");

    property p_wake;
        $rose(i_pin[0]) && mode0 == ICC_MODE_WAKE_RISE && i_int_enable[0]
            ##1 (mode0 == ICC_MODE_WAKE_RISE && i_int_enable[0] && !i_cpu_idle)[*2]
            |=> o_wake[0];
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake for a rising edge");
endmodule

bind icc_input_capture icc_input_capture_chk #(.NCH(NCH), .DEPTH(DEPTH)) u_chk (
    .i_clk(i_clk), .i_srst(i_srst), .i_pin(i_pin), .i_timer2(i_timer2),
    .i_timer3(i_timer3), .i_cpu_idle(i_cpu_idle), .i_cpu_sleep(i_cpu_sleep),
    .i_ctrl(i_ctrl), .i_int_enable(i_int_enable), .i_rd(i_rd), .i_ovf_clr(i_ovf_clr),
    .o_rd_data(o_rd_data), .o_status(o_status), .o_int_pulse(o_int_pulse), .o_wake(o_wake)
);

// File: icc_input_capture_tb.sv
// bench for the capture top: pin events, reads and flag checks
// assumes the pin model lags requested levels by one clock
`timescale 1ns/1ps
module icc_input_capture_tb;
    import icc_pkg::*;
    logic             i_clk;
    logic             i_srst;
    logic [7:0]       lvl;
    logic [7:0]       pin;
    logic [15:0]      t2;
    logic [15:0]      t3;
    logic             idle;
    logic             sleep;
    icc_ctrl_t [7:0]  ctrl;
    logic [7:0]       ien;
    logic [7:0]       rd;
    logic [7:0]       oclr;
    logic [7:0][15:0] rdat;
    icc_ctrl_t [7:0]  st;
    logic [7:0]       intp;
    logic [7:0]       wake;
    int               n_mismatch;
    int               checks;
    int               n_int;
    int               n_wake;
    int               cyc;
    int               base;

    icc_pin_model i_icc_pin_model (.i_clk(i_clk), .i_level(lvl), .o_pin(pin));
    icc_input_capture i_icc_input_capture (
        .i_clk(i_clk), .i_srst(i_srst), .i_pin(pin), .i_timer2(t2), .i_timer3(t3),
        .i_cpu_idle(idle), .i_cpu_sleep(sleep), .i_ctrl(ctrl), .i_int_enable(ien),
        .i_rd(rd), .i_ovf_clr(oclr), .o_rd_data(rdat), .o_status(st),
        .o_int_pulse(intp), .o_wake(wake)
    );

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard, far above the under a thousand cycles the tests need
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        n_int <= n_int + int'(intp[0] === 1'b1);
        n_wake <= n_wake + int'(wake[0] === 1'b1);
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // {overflow, not-empty} of one channel
    function automatic logic [1:0] fl(input int ch);
        return {st[ch].capture_overflow_flag, st[ch].buffer_not_empty_flag};
    endfunction

    // timers held steady so the captured word is known whatever the latency
    task automatic edge_ev(input logic [7:0] m, input logic lv, input logic [15:0] v);
        @(posedge i_clk);
        t3 <= v;
        t2 <= ~v;
        lvl <= lv ? (lvl | m) : (lvl & ~m);
        repeat (6) @(posedge i_clk);
        #1;
    endtask

    task automatic pulse(input logic [7:0] m, input logic [15:0] v);
        edge_ev(m, 1'b1, v);
        edge_ev(m, 1'b0, v);
    endtask

    task automatic setc(input int ch, input logic [2:0] md, input logic ts, input logic [1:0] e);
        @(posedge i_clk);
        ctrl[ch].capture_mode_select <= md;
        ctrl[ch].timebase_select <= ts;
        ctrl[ch].events_per_interrupt <= e;
        repeat (2) @(posedge i_clk);
        #1;
    endtask

    // no read is issued on an empty buffer, its word is undefined
    task automatic rd_chk(input int ch, input logic [15:0] exp);
        @(posedge i_clk);
        rd[ch] <= 1'b1;
        @(posedge i_clk);
        rd[ch] <= 1'b0;
        #1;
        check(rdat[ch], exp);
    endtask

    initial begin
        {i_srst, lvl, t2, t3, idle, sleep, ien, rd, oclr} = {1'b1, 60'h0};
        ctrl = '0;
        {n_mismatch, checks, n_int, n_wake, cyc} = '0;
        repeat (4) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        #1;
        // whole status vector is wider than the compare word, so go channel by channel
        for (int c = 0; c < 8; c++) check(32'(st[c]), '0);
        check({intp, wake, rdat[0]}, '0);
        $display("reset test done");

        setc(0, ICC_MODE_RISE, ICC_TMR_SEL_T3, 2'h2);
        base = n_int;
        for (int i = 1; i <= 4; i++) pulse(8'h01, 16'(i * 32'h1111));
        check(n_int - base, 1);
        check(fl(0), 2'h1);
        pulse(8'h01, 16'h5555);
        check(fl(0), 2'h3);
        rd_chk(0, 16'h1111);
        pulse(8'h01, 16'h6666);
        for (int i = 2; i <= 4; i++) rd_chk(0, 16'(i * 32'h1111));
        check(fl(0), 2'h2);
        pulse(8'h01, 16'h7777);
        rd_chk(0, 16'h7777);
        @(posedge i_clk);
        oclr[0] <= 1'b1;
        @(posedge i_clk);
        oclr[0] <= 1'b0;
        #1;
        check(fl(0), 2'h0);
        $display("buffer test done");

        // off first: the event count toward the next interrupt survives a mode change
        setc(0, ICC_MODE_OFF, 1'b0, 2'h0);
        setc(0, ICC_MODE_FALL, 1'b1, 2'h0);
        base = n_int;
        edge_ev(8'h01, 1'b1, 16'hA5A5);
        check(fl(0), 2'h0);
        edge_ev(8'h01, 1'b0, 16'h1234);
        rd_chk(0, 16'hEDCB);
        check(n_int - base, 1);
        $display("timer select test done");

        for (int k = 0; k < 2; k++) begin
            setc(0, ICC_MODE_OFF, 1'b0, 2'h0);
            setc(0, k ? ICC_MODE_RISE16 : ICC_MODE_RISE4, 1'b0, 2'h0);
            for (int i = 1; i < (k ? 16 : 4); i++) pulse(8'h01, 16'h0);
            check(fl(0), 2'h0);
            pulse(8'h01, 16'h00C3);
            rd_chk(0, 16'h00C3);
        end
        pulse(8'h01, 16'h0);
        setc(0, ICC_MODE_OFF, 1'b0, 2'h0);
        setc(0, ICC_MODE_RISE16, 1'b0, 2'h0);
        for (int i = 1; i < 16; i++) pulse(8'h01, 16'h0);
        check(fl(0), 2'h0);
        $display("prescaler test done");

        setc(0, ICC_MODE_EVERY_EDGE, 1'b0, 2'h3);
        setc(1, ICC_MODE_EVERY_EDGE, 1'b0, 2'h3);
        base = n_int;
        for (int i = 0; i < 4; i++) edge_ev(8'h03, !i[0], 16'(32'h100 + i));
        check(n_int - base, 4);
        edge_ev(8'h02, 1'b1, 16'h0);
        check(fl(1), 2'h1);
        for (int i = 0; i < 4; i++) rd_chk(0, 16'(32'h100 + i));
        check(fl(0), 2'h0);
        setc(1, ICC_MODE_OFF, 1'b0, 2'h0);
        $display("every edge test done");

        setc(0, ICC_MODE_WAKE_RISE, 1'b0, 2'h0);
        @(posedge i_clk);
        ien[0] <= 1'b1;
        sleep <= 1'b1;
        base = n_wake;
        pulse(8'h01, 16'h0);
        check(n_wake - base, 1);
        check(fl(0), 2'h0);
        @(posedge i_clk);
        ien[0] <= 1'b0;
        pulse(8'h01, 16'h0);
        check(n_wake - base, 1);
        @(posedge i_clk);
        sleep <= 1'b0;
        idle <= 1'b1;
        // idle-stop left at zero so capture runs in idle
        setc(0, ICC_MODE_RISE, 1'b0, 2'h0);
        pulse(8'h01, 16'h0BAD);
        rd_chk(0, 16'h0BAD);
        $display("wake and idle test done");
        print_verdict();
    end
endmodule

// File: icc_pin_model.sv
// far-side model: external signal on the capture pins
// assumes the bench asks for pin levels synchronous to i_clk
`timescale 1ns/1ps
module icc_pin_model (
    // clock
    input  wire logic       i_clk,
    // requested and driven levels
    input  wire logic [7:0] i_level,
    output logic      [7:0] o_pin
);
    // one clock of lag, like a board trace seen through a flop
    always_ff @(posedge i_clk) begin
        o_pin <= i_level;
    end
endmodule

// File: icc_pkg.sv
// constants and carriers for the eight-channel input capture block
// assumes one 40 MHz peripheral clock and 16-bit timer counts from outside
package icc_pkg;

    localparam int ICC_CHANNELS   = 8;
    localparam int ICC_TMR_W      = 16;
    localparam int ICC_FIFO_DEPTH = 4;
    localparam int ICC_CNT_W      = $clog2(ICC_FIFO_DEPTH + 1);

    // capture_mode_select codes
    localparam logic [2:0] ICC_MODE_OFF        = 3'h0;
    localparam logic [2:0] ICC_MODE_EVERY_EDGE = 3'h1;
    localparam logic [2:0] ICC_MODE_FALL       = 3'h2;
    localparam logic [2:0] ICC_MODE_RISE       = 3'h3;
    localparam logic [2:0] ICC_MODE_RISE4      = 3'h4;
    localparam logic [2:0] ICC_MODE_RISE16     = 3'h5;
    localparam logic [2:0] ICC_MODE_WAKE_RISE  = 3'h7;

    // prescaler edge counter and interrupt event counter
    localparam logic [3:0] ICC_PRESC_RST     = 4'h0;
    localparam logic [3:0] ICC_PRESC4_LAST   = 4'h3;
    localparam logic [3:0] ICC_PRESC16_LAST  = 4'hF;
    localparam logic [3:0] ICC_PRESC_STEP    = 4'h1;
    localparam logic [1:0] ICC_ICNT_RST      = 2'h0;
    localparam logic [1:0] ICC_ICNT_STEP     = 2'h1;

    // timebase_select value that picks the second timer (reset state)
    localparam logic ICC_TMR_SEL_T3 = 1'b0;

    // capture_control_reg layout, bit 15 down to bit 0
    typedef struct packed {
        logic [1:0] rsvd_15_14;
        logic       idle_stop_bit;          // bit 13
        logic [4:0] rsvd_12_8;
        logic       timebase_select;        // bit 7
        logic [1:0] events_per_interrupt;   // bits 6:5
        logic       capture_overflow_flag;  // bit 4
        logic       buffer_not_empty_flag;  // bit 3
        logic [2:0] capture_mode_select;    // bits 2:0
    } icc_ctrl_t;

    localparam icc_ctrl_t ICC_CTRL_RST = '0;

    // per-channel state of the capture top
    typedef struct packed {
        logic [3:0]           presc;
        logic [1:0]           icnt;
        logic                 blocked;
        logic [ICC_TMR_W-1:0] rd_data;
        logic                 int_pulse;
        logic                 wake_pulse;
        icc_ctrl_t            status;
    } icc_chan_t;

endpackage

// File: icc_sync.sv
// two-stage pin synchroniser with edge detect
// assumes the pin is asynchronous; edges are seen two to three clocks late
`timescale 1ns/1ps
module icc_sync (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_srst,
    // pin and edges
    input  wire logic i_pin,
    output logic      o_rise,
    output logic      o_fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } icc_sync_st_t;

    icc_sync_st_t q;
    icc_sync_st_t d;

    always_comb begin
        d    = q;
        d.s1 = i_pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // edges look at stages two and three only, never the first stage
    assign o_rise = q.s2 & ~q.s3;
    assign o_fall = ~q.s2 & q.s3;
endmodule
